// File: bench/power_alarm_assertions.sv
// Checker for the power-mode and alarm slice.
// Assumes only the top module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "power_alarm_map.svh"
module power_alarm_assertions (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic soft_reset_i,
	input wire power_alarm_pkg::reg_req_t req_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	input wire power_alarm_pkg::alarm_events_t events_i,
	input wire power_alarm_pkg::status_pin_sel_t status_pin_sel_i,
	input wire logic cal_status_i,
	input wire power_alarm_pkg::power_codes_t power_codes_o,
	input wire logic alarm_summary_o,
	input wire logic calibration_status_pin_o
);
	// ==========
	// Properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i || soft_reset_i);
	wire logic rd = req_i.rd_en;
	wire logic sel = status_pin_sel_i == power_alarm_pkg::STATUS_PIN_ALARM;
	wire logic [11:0] a = req_i.addr;
	a_read_answer: assert property (rd |=> rvalid_o) else $error("no read answer");
	a_code2_store: assert property (req_i.wr_en && a == `ADDR_POWER_MODE_SELECT_2
		|=> power_codes_o.power_code_2 == $past(req_i.wdata)) else $error("code2 lost");
	a_codes_hold: assert property (!req_i.wr_en |=> $stable(power_codes_o))
		else $error("codes moved");
	a_summary_read: assert property (rd && a == `ADDR_ALARM_SUMMARY
		|=> rdata_o == {7'h00, $past(alarm_summary_o)}) else $error("summary read");
	a_status_fixed: assert property (rd && a == `ADDR_ALARM_STICKY_STATUS
		|=> rdata_o[7:6] == 2'h0 && rdata_o[1]) else $error("status reserved");
	a_fifo_sticky: assert property (events_i.lane_fifo_alarm ##1 !req_i.wr_en
		##1 rd && a == `ADDR_ALARM_STICKY_STATUS |=> rdata_o[5]) else $error("fifo lost");
	a_pin_alarm: assert property (sel |=> calibration_status_pin_o == $past(alarm_summary_o))
		else $error("pin alarm");
	a_pin_cal: assert property (!sel |=> calibration_status_pin_o == $past(cal_status_i))
		else $error("pin cal");
	a_unmapped_read: assert property (rd
		&& !(a inside {[12'h29A:12'h29C], [12'h2C0:12'h2C2]}) |=> rdata_o == 8'h00)
		else $error("unmapped read");
	c_fifo_event: cover property (events_i.lane_fifo_alarm);
	c_summary_up: cover property ($rose(alarm_summary_o));
	c_pin_cal: cover property (!sel ##1 calibration_status_pin_o);
endmodule
bind power_mode_and_alarm_regs power_alarm_assertions u_chk (
	.clk_i(clk_i),
	.nrst_i(nrst_i),
	.soft_reset_i(soft_reset_i),
	.req_i(req_i),
	.rdata_o(rdata_o),
	.rvalid_o(rvalid_o),
	.events_i(events_i),
	.status_pin_sel_i(status_pin_sel_i),
	.cal_status_i(cal_status_i),
	.power_codes_o(power_codes_o),
	.alarm_summary_o(alarm_summary_o),
	.calibration_status_pin_o(calibration_status_pin_o)
);
`default_nettype wire

// File: bench/power_mode_and_alarm_regs_tb_top.sv
// Self-checking bench for the power-mode and alarm slice.
// Assumes design, package and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "power_alarm_map.svh"
module power_mode_and_alarm_regs_tb_top;
	logic clk_i = 0;
	logic nrst_i = 0;
	logic soft_reset_i = 0;
	logic cal_status_i = 0;
	logic [7:0] rdata_o;
	logic rvalid_o, alarm_summary_o, calibration_status_pin_o;
	power_alarm_pkg::reg_req_t req_i = '0;
	power_alarm_pkg::alarm_events_t events_i = '0;
	power_alarm_pkg::status_pin_sel_t status_pin_sel_i = power_alarm_pkg::STATUS_PIN_ALARM;
	power_alarm_pkg::power_codes_t power_codes_o;
	int n_mismatch = 0;
	int cmp_count = 0;
	power_mode_and_alarm_regs u_dut (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.soft_reset_i(soft_reset_i),
		.req_i(req_i),
		.rdata_o(rdata_o),
		.rvalid_o(rvalid_o),
		.events_i(events_i),
		.status_pin_sel_i(status_pin_sel_i),
		.cal_status_i(cal_status_i),
		.power_codes_o(power_codes_o),
		.alarm_summary_o(alarm_summary_o),
		.calibration_status_pin_o(calibration_status_pin_o)
	);
	always #2 clk_i = ~clk_i;
	// ==========
	// Tasks
	task automatic step(); @(posedge clk_i); #1; endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		req_i = '{1'b1, 1'b0, a, d};
		step();
		req_i = '0;
		step();
	endtask
	task automatic rd(logic [11:0] a, logic [7:0] e);
		req_i = '{1'b0, 1'b1, a, 8'h00};
		step();
		req_i = '0;
		chk("rvalid", 8'h01, {7'h00, rvalid_o});
		chk("rdata", e, rdata_o);
		step();
	endtask
	function automatic logic [7:0] code(int r, bit m);
		case (r)
			0: return m ? `POWER_CODE_2_HIGH : `POWER_CODE_2_LOW;
			1: return m ? `POWER_CODE_3_HIGH : `POWER_CODE_3_LOW;
			default: return m ? `POWER_CODE_4_HIGH : `POWER_CODE_4_LOW;
		endcase
	endfunction
	task automatic report_and_stop();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// Sequence
	initial begin
		bit m;
		logic [7:0] b;
		b = 8'($urandom(52));
		repeat (5) step();
		nrst_i = 1;
		step();
		for (int r = 0; r < 3; r++) rd(12'(12'h29A + r), code(r, 1));
		rd(`ADDR_ALARM_SUMMARY, 8'h00);
		rd(`ADDR_ALARM_STICKY_STATUS, 8'h3F);
		rd(`ADDR_ALARM_MASK, 8'h3F);
		rd(12'h123, 8'h00);
		repeat (4) begin
			m = 1'($urandom);
			// Whole set at once; calibration and link idle, rate at most 1 GSPS
			for (int r = 0; r < 3; r++) wr(12'(12'h29A + r), code(r, m));
			chk("code2", code(0, m), power_codes_o.power_code_2);
			chk("code3", code(1, m), power_codes_o.power_code_3);
			chk("code4", code(2, m), power_codes_o.power_code_4);
			for (int r = 0; r < 3; r++) rd(12'(12'h29A + r), code(r, m));
		end
		wr(`ADDR_ALARM_STICKY_STATUS, 8'hFF);
		rd(`ADDR_ALARM_STICKY_STATUS, 8'h02);
		for (int i = 0; i < 5; i++) begin
			m = 1'($urandom);
			b = i == 0 ? 8'h01 : 8'(8'h01 << (i + 1));
			wr(`ADDR_ALARM_MASK, m ? b : 8'h00);
			events_i = power_alarm_pkg::alarm_events_t'(5'(1 << i));
			step();
			events_i = '0;
			chk("summary", {7'h00, !m}, {7'h00, alarm_summary_o});
			step();
			chk("pin", {7'h00, !m}, {7'h00, calibration_status_pin_o});
			rd(`ADDR_ALARM_STICKY_STATUS, 8'h02 | b);
			wr(`ADDR_ALARM_STICKY_STATUS, b);
			rd(`ADDR_ALARM_SUMMARY, 8'h00);
		end
		// Event held through the clear cycle and the cycle after it: the bit reads set
		events_i.lane_fifo_alarm = 1'b1;
		wr(`ADDR_ALARM_STICKY_STATUS, 8'h20);
		events_i = '0;
		rd(`ADDR_ALARM_STICKY_STATUS, 8'h22);
		wr(`ADDR_ALARM_STICKY_STATUS, 8'h20);
		rd(`ADDR_ALARM_STICKY_STATUS, 8'h02);
		status_pin_sel_i = power_alarm_pkg::STATUS_PIN_CAL;
		repeat (6) begin
			cal_status_i = 1'($urandom);
			step();
			step();
			chk("pin cal", {7'h00, cal_status_i}, {7'h00, calibration_status_pin_o});
		end
		for (int r = 0; r < 3; r++) wr(12'(12'h29A + r), code(r, 1'b0));
		soft_reset_i = 1;
		step();
		soft_reset_i = 0;
		step();
		for (int r = 0; r < 3; r++) rd(12'(12'h29A + r), code(r, 1'b1));
		rd(`ADDR_ALARM_STICKY_STATUS, `ALARM_STATUS_RESET);
		rd(`ADDR_ALARM_MASK, `ALARM_MASK_RESET);
		report_and_stop();
	end
endmodule
`default_nettype wire

// File: rtl/power_alarm_map.svh
// Register offsets, field positions and reset values of the power-mode and alarm slice.
// Assumes a 12-bit register address from the serial register port.
`ifndef POWER_ALARM_MAP_SVH
`define POWER_ALARM_MAP_SVH

`define ADDR_POWER_MODE_SELECT_2 12'h29A
`define ADDR_POWER_MODE_SELECT_3 12'h29B
`define ADDR_POWER_MODE_SELECT_4 12'h29C
`define ADDR_ALARM_SUMMARY 12'h2C0
`define ADDR_ALARM_STICKY_STATUS 12'h2C1
`define ADDR_ALARM_MASK 12'h2C2

`define POWER_CODE_2_LOW 8'h06
`define POWER_CODE_2_HIGH 8'h0F
`define POWER_CODE_3_LOW 8'h00
`define POWER_CODE_3_HIGH 8'h04
`define POWER_CODE_4_LOW 8'h14
`define POWER_CODE_4_HIGH 8'h1B

`define ALARM_STATUS_RESET 8'h3F
`define ALARM_MASK_RESET 8'h3F
`define ALARM_STATUS_RW_BITS 8'h3F
`define ALARM_MASK_RW_BITS 8'h3F

`define ALARM_BIT_FIFO 5
`define ALARM_BIT_PLL 4
`define ALARM_BIT_LINK 3
`define ALARM_BIT_REALIGN 2
`define ALARM_BIT_RSVD 1
`define ALARM_BIT_CLOCK 0

`endif

// File: rtl/power_alarm_pkg.sv
// Types of the power-mode and alarm register slice.
// Assumes nothing beyond the map header for numbers.
`default_nettype none
package power_alarm_pkg;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [11:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic lane_fifo_alarm;
		logic serializer_pll_alarm;
		logic link_state_alarm;
		logic clock_realign_alarm;
		logic divider_mismatch_alarm;
	} alarm_events_t;

	typedef struct packed {
		logic [7:0] power_code_2;
		logic [7:0] power_code_3;
		logic [7:0] power_code_4;
	} power_codes_t;

	typedef enum logic {
		STATUS_PIN_CAL,
		STATUS_PIN_ALARM
	} status_pin_sel_t;

endpackage

`default_nettype wire

// File: rtl/power_mode_and_alarm_regs.sv
// Power-mode selection registers and alarm status/mask/summary of a converter.
// Assumes register requests are one-cycle strobes synchronous to clk_i from the serial port.
`timescale 1ns/100ps
`default_nettype none
`include "power_alarm_map.svh"

module power_mode_and_alarm_regs #(
	parameter int unsigned REG_W = 8,
	parameter int unsigned ADDR_W = 12
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic soft_reset_i,
	input wire power_alarm_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	input wire power_alarm_pkg::alarm_events_t events_i,
	input wire power_alarm_pkg::status_pin_sel_t status_pin_sel_i,
	input wire logic cal_status_i,
	output power_alarm_pkg::power_codes_t power_codes_o,
	output logic alarm_summary_o,
	output logic calibration_status_pin_o
);

	// ==========================================================
	// Register state
	power_alarm_pkg::power_codes_t codes_q, codes_d;
	logic [REG_W-1:0] status_q, status_d;
	logic [REG_W-1:0] mask_q, mask_d;
	logic [REG_W-1:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic pin_q, pin_d;
	logic [REG_W-1:0] event_vec;
	logic [ADDR_W-1:0] addr;
	logic clear_all;
	logic summary;
	logic wr_mode2;
	logic wr_mode3;
	logic wr_mode4;
	logic wr_status;
	logic wr_mask;

	// ==========================================================
	// Parameter checks; the port structs fix both widths
	if (REG_W != $bits(req_i.wdata)) begin : g_bad_reg_w
		$error("REG_W must equal the register data width");
	end
	if (ADDR_W != $bits(req_i.addr)) begin : g_bad_addr_w
		$error("ADDR_W must equal the register address width");
	end

	// ==========================================================
	// Bit classes of the alarm registers
	localparam logic [REG_W-1:0] STATUS_LIVE = `ALARM_STATUS_RW_BITS;
	localparam logic [REG_W-1:0] MASK_LIVE = `ALARM_MASK_RW_BITS;
	localparam logic [REG_W-1:0] RSVD_ONE = REG_W'(1) << `ALARM_BIT_RSVD;

	// ==========================================================
	// Request decode; power-on and soft reset act alike
	assign clear_all = !nrst_i || soft_reset_i;
	assign addr = req_i.addr;
	assign wr_mode2 = req_i.wr_en && addr == `ADDR_POWER_MODE_SELECT_2;
	assign wr_mode3 = req_i.wr_en && addr == `ADDR_POWER_MODE_SELECT_3;
	assign wr_mode4 = req_i.wr_en && addr == `ADDR_POWER_MODE_SELECT_4;
	assign wr_status = req_i.wr_en && addr == `ADDR_ALARM_STICKY_STATUS;
	assign wr_mask = req_i.wr_en && addr == `ADDR_ALARM_MASK;

	// ==========================================================
	// Alarm sources mapped to status bit positions
	always_comb begin
		event_vec = '0;
		event_vec[`ALARM_BIT_FIFO] = events_i.lane_fifo_alarm;
		event_vec[`ALARM_BIT_PLL] = events_i.serializer_pll_alarm;
		event_vec[`ALARM_BIT_LINK] = events_i.link_state_alarm;
		event_vec[`ALARM_BIT_REALIGN] = events_i.clock_realign_alarm;
		event_vec[`ALARM_BIT_CLOCK] = events_i.divider_mismatch_alarm;
	end

	// ==========================================================
	// Power-mode selection; reserved codes stored as written
	always_comb begin
		codes_d = codes_q;
		if (wr_mode2) begin
			codes_d.power_code_2 = req_i.wdata;
		end
		if (wr_mode3) begin
			codes_d.power_code_3 = req_i.wdata;
		end
		if (wr_mode4) begin
			codes_d.power_code_4 = req_i.wdata;
		end
	end

	// High-performance codes after either reset
	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			codes_q.power_code_2 <= `POWER_CODE_2_HIGH;
			codes_q.power_code_3 <= `POWER_CODE_3_HIGH;
			codes_q.power_code_4 <= `POWER_CODE_4_HIGH;
		end else begin
			codes_q <= codes_d;
		end
	end

	// ==========================================================
	// Alarm mask
	always_comb begin
		mask_d = mask_q;
		if (wr_mask) begin
			// Reserved bit 1 stays at its default of one
			mask_d = (req_i.wdata & MASK_LIVE & ~RSVD_ONE) | RSVD_ONE;
		end
	end

	// ==========================================================
	// Sticky status, one bit at a time; set wins over a clear
	for (genvar g = 0; g < REG_W; g++) begin : g_status_bit
		if (!STATUS_LIVE[g]) begin : g_unused
			assign status_d[g] = 1'h0;
		end else if (RSVD_ONE[g]) begin : g_reserved
			assign status_d[g] = status_q[g];
		end else begin : g_sticky
			assign status_d[g] = event_vec[g]
				| (status_q[g] & ~(wr_status & req_i.wdata[g]));
		end
	end

	// Every alarm reads as raised after either reset
	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			status_q <= `ALARM_STATUS_RESET;
			mask_q <= `ALARM_MASK_RESET;
		end else begin
			status_q <= status_d;
			mask_q <= mask_d;
		end
	end

	// Masked alarms stay recorded but leave the summary
	assign summary = |(status_q & ~mask_q);

	// ==========================================================
	// Read port; answer one cycle after the strobe
	always_comb begin
		rvalid_d = req_i.rd_en;
		rdata_d = '0;
		if (req_i.rd_en) begin
			case (addr)
				`ADDR_POWER_MODE_SELECT_2: begin
					rdata_d = codes_q.power_code_2;
				end
				`ADDR_POWER_MODE_SELECT_3: begin
					rdata_d = codes_q.power_code_3;
				end
				`ADDR_POWER_MODE_SELECT_4: begin
					rdata_d = codes_q.power_code_4;
				end
				`ADDR_ALARM_SUMMARY: begin
					rdata_d = REG_W'(summary);
				end
				`ADDR_ALARM_STICKY_STATUS: begin
					rdata_d = status_q;
				end
				`ADDR_ALARM_MASK: begin
					rdata_d = mask_q;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			rdata_q <= '0;
			rvalid_q <= 1'h0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ==========================================================
	// Status pin source
	always_comb begin
		if (status_pin_sel_i == power_alarm_pkg::STATUS_PIN_ALARM) begin
			pin_d = summary;
		end else begin
			pin_d = cal_status_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			pin_q <= 1'h0;
		end else begin
			pin_q <= pin_d;
		end
	end

	// ==========================================================
	// Outputs
	assign rdata_o = rdata_q;
	assign rvalid_o = rvalid_q;
	assign power_codes_o = codes_q;
	assign alarm_summary_o = summary;
	assign calibration_status_pin_o = pin_q;

endmodule

`default_nettype wire
